// [core/eeprom_pkg.sv]
// Shared constants for the two-wire EEPROM target and its bus controller.
// Assumes both ends run from the same 200 MHz system clock rate.
`default_nettype none

package eeprom_pkg;
   // System clock rate, used to turn times into cycles
   localparam int CLK_MHZ = 200;
   // Longest self-timed write, in ms, and its cycle count (exact product)
   localparam int WR_TIME_MS = 5;
   localparam int WR_CYCLES  = WR_TIME_MS * 1000 * CLK_MHZ;
   // Width of the write-cycle timer, large enough for WR_CYCLES
   localparam int BUSY_W = 20;
   // Serial clock period made by the controller, in ns, and cycles per quarter;
   // 1 MHz keeps transfers short, a slower bus needs a longer period here
   localparam int SCL_TIME_NS = 1000;
   localparam int SCL_QTR     = SCL_TIME_NS * CLK_MHZ / 4000;
   // Fixed type prefix of the device address word
   localparam logic [3:0] DEV_TYPE = 4'hA;
   // Array size and address width
   localparam int MEM_BYTES = 128;
   localparam int ADDR_W    = 7;
   // Bit counter values: last data bit seen, and acknowledge slot
   localparam logic [3:0] CNT_BYTE = 4'h8;
   localparam logic [3:0] CNT_ACK  = 4'h9;
   // Controller commands
   typedef enum logic [2:0] {OP_START, OP_STOP, OP_WRITE, OP_READ, OP_RECOVER} op_t;
endpackage

`default_nettype wire

// [core/two_wire_if.sv]
// Two-wire bus between one controller and one EEPROM target.
// Assumes an external pull-up: the data line is low when either end drives.
`default_nettype none

interface two_wire_if;
   logic scl;          // Serial clock, made by the controller
   logic sda;          // Resolved data line level
   logic sda_tgt_out;  // Target drive value (always low)
   logic sda_tgt_oe_b; // Target drives while low
   logic sda_ctl_out;  // Controller drive value (always low)
   logic sda_ctl_oe_b; // Controller drives while low

   // Wired-AND with pull-up
   assign sda = ((!sda_tgt_oe_b && !sda_tgt_out) || (!sda_ctl_oe_b && !sda_ctl_out))
                ? 1'b0 : 1'b1;

   modport target (input scl, input sda, output sda_tgt_out, output sda_tgt_oe_b);
   modport controller (output scl, input sda, output sda_ctl_out, output sda_ctl_oe_b);
endinterface

`default_nettype wire

// [core/eeprom_target.sv]
// Target end of the two-wire bus: a 128-byte EEPROM with page writes.
// Assumes the serial clock and data arrive asynchronously and are synchronised
// here; the controller end drives the serial clock.
// Function
// - Data changes only while clock low
// - Falling data, clock high: start
// - Rising data, clock high: stop; standby
// - Eight-bit words, acknowledge on ninth clock
// - Standby at power-up and after stop
// - Recovery: start, nine clocks, start, stop
// - Address word: type prefix plus three straps
// - Address bit zero selects read or write
// - Match acknowledges; mismatch returns to standby
// - Byte write: word address, data, stop
// - Stop starts 5 ms write, inputs ignored
// - Page write up to eight bytes
// - Write address wraps inside page
// - Polling acknowledged only after write completes
// - Address counter holds last access plus one
// - Read address wraps over whole array
// - Current read sends byte at counter
// - Random read via dummy write, repeated start
// - Controller acknowledge continues sequential read
// - Sample on rise, change after fall
// - 128 bytes, 16 pages, 7-bit address
// - Protect pin high blocks all writes
`default_nettype none

module eeprom_target
   import eeprom_pkg::*;
#(
   parameter int unsigned WR_CYCLES_P = eeprom_pkg::WR_CYCLES // Write cycle length
) (
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          rst_b,
   // Bus pins
   two_wire_if.target         bus,
   // Straps and protect pin
   input  wire logic          chip_select_strap_2,
   input  wire logic          chip_select_strap_1,
   input  wire logic          chip_select_strap_0,
   input  wire logic          write_protect,
   // Status
   output var  logic          busy
);
   import eeprom_pkg::*;

   // Protocol states; S_IDLE is standby
   typedef enum logic [2:0] {S_IDLE, S_DEV, S_WADDR, S_WDATA, S_TX} tstate_t;

   // Whole state of the target
   typedef struct packed {
      logic [2:0]        scl_s;    // Stage 1, stage 2, previous
      logic [2:0]        sda_s;    // Stage 1, stage 2, previous
      logic [3:0]        pin_s1;   // Straps and protect, first stage
      logic [3:0]        pin_s2;   // Straps and protect, second stage
      tstate_t           st;       // Protocol state
      logic [3:0]        cnt;      // Clock count in the current word
      logic [7:0]        sh;       // Receive or transmit shifter
      logic [ADDR_W-1:0] addr;     // Word address counter
      logic              mack;     // Controller acknowledged last byte
      logic              oe_b;     // Data line drive, low drives zero
      logic [63:0]       page;     // Page buffer, byte n at bits 8n+7:8n
      logic [7:0]        mask;     // Page buffer bytes written
      logic [BUSY_W-1:0] busy_cnt; // Write cycle timer
      logic              busy;     // Write cycle in progress
   } tgt_t;

   tgt_t        q;                  // Registered state
   tgt_t        d;                  // Next state
   logic [7:0]  mem [MEM_BYTES];    // The array, 16 pages of 8 bytes
   logic        commit;             // Copy page buffer into the array
   logic        scl_rise;           // Serial clock rising edge
   logic        scl_fall;           // Serial clock falling edge
   logic        start;              // Start condition seen
   logic        stop;               // Stop condition seen
   logic        sda;                // Synchronised data level
   logic [2:0]  straps;             // Synchronised straps
   logic        wp;                 // Synchronised protect pin
   logic [7:0]  rd_byte;            // Array byte at the counter

   // Next-state logic
   always_comb begin
      d        = q;
      commit   = 1'b0;
      rd_byte  = mem[q.addr];
      // Two flip-flops before use; stage 1 feeds only stage 2
      d.scl_s  = {q.scl_s[1:0], bus.scl};
      d.sda_s  = {q.sda_s[1:0], bus.sda};
      d.pin_s1 = {chip_select_strap_2, chip_select_strap_1, chip_select_strap_0,
                  write_protect};
      d.pin_s2 = q.pin_s1;
      sda      = q.sda_s[1];
      straps   = q.pin_s2[3:1];
      wp       = q.pin_s2[0];
      scl_rise = q.scl_s[1] & ~q.scl_s[2];
      scl_fall = ~q.scl_s[1] & q.scl_s[2];
      // Data moving while clock stays high is a condition, not data
      start    = q.scl_s[1] & q.scl_s[2] & ~q.sda_s[1] & q.sda_s[2];
      stop     = q.scl_s[1] & q.scl_s[2] & q.sda_s[1] & ~q.sda_s[2];

      if (q.busy) begin
         // Self-timed write: bus ignored, polls get no acknowledge
         d.st   = S_IDLE;
         d.oe_b = 1'b1;
         if (q.busy_cnt == '0) begin
            d.busy = 1'b0;  // Back to standby once the write ends
         end else begin
            d.busy_cnt = q.busy_cnt - 1'b1;
         end
      end else if (start) begin
         // Start or repeated start: expect a device address word
         d.st   = S_DEV;
         d.cnt  = '0;
         d.oe_b = 1'b1;
         d.mask = '0;
      end else if (stop) begin
         // Stop always returns to standby
         d.st   = S_IDLE;
         d.oe_b = 1'b1;
         d.mask = '0;
         // Written bytes start the write cycle unless protected
         if (|q.mask && !wp) begin
            commit     = 1'b1;
            d.busy     = 1'b1;
            d.busy_cnt = BUSY_W'(WR_CYCLES_P - 1);
         end
      end else if (scl_rise && q.st != S_IDLE) begin
         // Inputs sampled on the rising edge
         if (q.st == S_TX) begin
            if (q.cnt < CNT_BYTE) begin
               d.cnt = q.cnt + 4'h1;
            end else if (q.cnt == CNT_BYTE) begin
               d.mack = ~sda;  // Controller acknowledge on the ninth clock
               d.cnt  = CNT_ACK;
            end
         end else if (q.cnt < CNT_BYTE) begin
            d.sh  = {q.sh[6:0], sda};  // Words arrive most significant first
            d.cnt = q.cnt + 4'h1;
         end
      end else if (scl_fall && q.st != S_IDLE) begin
         // Outputs change only after the falling edge
         if (q.cnt == CNT_ACK) begin
            if (q.st != S_TX) begin
               d.oe_b = 1'b1;  // End of our acknowledge
               d.cnt  = '0;
            end else if (q.mack) begin
               // Send the byte at the counter, then step it
               d.sh   = rd_byte;
               d.oe_b = rd_byte[7];
               d.addr = q.addr + 7'h01;  // Wraps over the whole array
               d.cnt  = '0;
            end else begin
               // No acknowledge: wait for the stop in standby
               d.st   = S_IDLE;
               d.oe_b = 1'b1;
            end
         end else if (q.st == S_TX) begin
            if (q.cnt == CNT_BYTE) begin
               d.oe_b = 1'b1;  // Free the line for the controller acknowledge
            end else if (q.cnt != '0) begin
               d.sh   = {q.sh[6:0], 1'b0};
               d.oe_b = q.sh[6];
            end
         end else if (q.cnt == CNT_BYTE) begin
            // A whole word received: act on it and acknowledge
            d.cnt  = CNT_ACK;
            d.oe_b = 1'b0;
            case (q.st)
               S_DEV: begin
                  // Type prefix and straps must match
                  if (q.sh[7:4] == DEV_TYPE && q.sh[3:1] == straps) begin
                     if (q.sh[0]) begin
                        d.st   = S_TX;  // One selects a read
                        d.mack = 1'b1;
                     end else begin
                        d.st = S_WADDR;  // Zero selects a write
                     end
                  end else begin
                     d.st   = S_IDLE;  // No acknowledge, back to standby
                     d.oe_b = 1'b1;
                     d.cnt  = '0;
                  end
               end
               S_WADDR: begin
                  // Word address load; top bit dropped
                  d.addr = q.sh[ADDR_W-1:0];
                  d.st   = S_WDATA;
               end
               S_WDATA: begin
                  // Buffer the byte; more bytes make a page write
                  d.page[q.addr[2:0]*8 +: 8] = q.sh;
                  d.mask[q.addr[2:0]]        = 1'b1;
                  // Only the low three bits step, wrapping in the page
                  d.addr = {q.addr[6:3], q.addr[2:0] + 3'h1};
               end
               default: begin
                  d.st   = S_IDLE;
                  d.oe_b = 1'b1;
               end
            endcase
         end
      end
   end

   // State register; standby after reset
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         q       <= '0;
         q.scl_s <= 3'h7;
         q.sda_s <= 3'h7;
         q.oe_b  <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // Array update at the start of the write cycle; only written bytes change
   // so a partial page leaves the rest of the page intact
   always_ff @(posedge clk) begin
      for (int i = 0; i < 8; i++) begin
         if (commit && q.mask[i]) begin
            mem[{q.addr[6:3], 3'(i)}] <= q.page[i*8 +: 8];
         end
      end
   end

   // Outputs straight from the state register; open drain drives only zero
   assign bus.sda_tgt_out  = 1'b0;
   assign bus.sda_tgt_oe_b = q.oe_b;
   assign busy             = q.busy;
endmodule

`default_nettype wire

// [core/bus_controller.sv]
// Controller end of the two-wire bus: makes the serial clock and runs
// start, stop, byte write, byte read and bus recovery on command.
// Assumes one command at a time, taken only while cmd_ready is high.
`default_nettype none

module bus_controller
   import eeprom_pkg::*;
(
   // Clock and reset
   input  wire logic            clk,
   input  wire logic            rst_b,
   // Bus pins
   two_wire_if.controller       bus,
   // Command
   input  wire logic            cmd_valid,
   input  wire eeprom_pkg::op_t cmd_op,
   input  wire logic [7:0]      cmd_byte,
   input  wire logic            cmd_ack,
   output var  logic            cmd_ready,
   // Result
   output var  logic            done,
   output var  logic [7:0]      rd_byte,
   output var  logic            ack_seen
);
   import eeprom_pkg::*;

   // Sequencer states
   typedef enum logic [1:0] {C_IDLE, C_START, C_BITS, C_STOP} cstate_t;

   // Whole state of the controller
   typedef struct packed {
      cstate_t     st;    // Sequencer state
      logic [1:0]  ph;    // Quarter of the bit or condition
      logic [7:0]  div;   // Quarter-period divider
      logic        scl;   // Serial clock out
      logic        oe_b;  // Data drive, low drives zero
      logic [8:0]  sh;    // Nine bits to send, MSB first
      logic [8:0]  rx;    // Nine bits seen
      logic [3:0]  bcnt;  // Bits left
      logic [1:0]  rec;   // Recovery step, zero when not recovering
      logic        ready; // Idle and able to take a command
      logic        done;  // Command finished
      logic [7:0]  rd;    // Byte read
      logic        ack;   // Acknowledge seen on the ninth bit
      logic [1:0]  sda_s; // Data line synchroniser
   } ctl_t;

   ctl_t q;    // Registered state
   ctl_t d;    // Next state
   logic tick; // End of a quarter period

   // Next-state logic
   always_comb begin
      d       = q;
      d.sda_s = {q.sda_s[0], bus.sda};
      d.done  = 1'b0;
      tick    = (q.div == '0);
      // Clock divider; the link clock is derived here, not a second domain
      d.div   = tick ? 8'(SCL_QTR - 1) : q.div - 8'h01;
      case (q.st)
         C_IDLE: begin
            if (cmd_valid && q.ready) begin
               d.ready = 1'b0;
               d.ph    = '0;
               d.rec   = '0;
               case (cmd_op)
                  OP_START: d.st = C_START;
                  OP_STOP:  d.st = C_STOP;
                  OP_WRITE: begin
                     // Byte MSB first, ninth bit released for the target
                     d.sh   = {cmd_byte, 1'b1};
                     d.bcnt = 4'h9;
                     d.st   = C_BITS;
                  end
                  OP_READ: begin
                     // Release eight bits, then acknowledge or not
                     d.sh   = {8'hFF, ~cmd_ack};
                     d.bcnt = 4'h9;
                     d.st   = C_BITS;
                  end
                  OP_RECOVER: begin
                     d.rec = 2'h3;  // Start, nine clocks, start, stop
                     d.st  = C_START;
                  end
                  default: d.ready = 1'b1;
               endcase
            end
         end
         C_START: begin
            if (tick) begin
               d.ph = q.ph + 2'h1;
               case (q.ph)
                  2'h0: d.oe_b = 1'b1;  // Data high while clock low
                  2'h1: d.scl  = 1'b1;
                  2'h2: d.oe_b = 1'b0;  // Data falls with clock high
                  default: begin
                     d.scl = 1'b0;
                     if (q.rec == 2'h3) begin
                        d.rec  = 2'h2;  // Nine released clocks follow
                        d.sh   = 9'h1FF;
                        d.bcnt = 4'h9;
                        d.st   = C_BITS;
                     end else if (q.rec == 2'h1) begin
                        d.rec = 2'h0;  // Stop straight after second start
                        d.st  = C_STOP;
                     end else begin
                        d.st    = C_IDLE;
                        d.ready = 1'b1;
                        d.done  = 1'b1;
                     end
                  end
               endcase
            end
         end
         C_BITS: begin
            if (tick) begin
               d.ph = q.ph + 2'h1;
               case (q.ph)
                  2'h0: d.oe_b = q.sh[8];  // Data changes only with clock low
                  2'h1: d.scl  = 1'b1;
                  2'h2: d.rx   = {q.rx[7:0], q.sda_s[1]};  // Sample mid-high
                  default: begin
                     d.scl  = 1'b0;
                     d.sh   = {q.sh[7:0], 1'b1};
                     d.bcnt = q.bcnt - 4'h1;
                     if (q.bcnt == 4'h1) begin
                        d.oe_b = 1'b1;  // Free the line for the next word
                        d.rd   = q.rx[8:1];
                        d.ack  = ~q.rx[0];  // Target acknowledge is a zero
                        if (q.rec == 2'h2) begin
                           d.rec = 2'h1;
                           d.st  = C_START;
                        end else begin
                           d.st    = C_IDLE;
                           d.ready = 1'b1;
                           d.done  = 1'b1;
                        end
                     end
                  end
               endcase
            end
         end
         C_STOP: begin
            if (tick) begin
               d.ph = q.ph + 2'h1;
               case (q.ph)
                  2'h0: d.oe_b = 1'b0;  // Data low while clock low
                  2'h1: d.scl  = 1'b1;
                  2'h2: d.oe_b = 1'b1;  // Data rises with clock high
                  default: begin
                     d.st    = C_IDLE;
                     d.ready = 1'b1;
                     d.done  = 1'b1;
                  end
               endcase
            end
         end
         default: d.st = C_IDLE;
      endcase
   end

   // State register; bus idle with both lines released after reset
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         q       <= '0;
         q.scl   <= 1'b1;
         q.oe_b  <= 1'b1;
         q.ready <= 1'b1;
         q.sda_s <= 2'h3;
      end else begin
         q <= d;
      end
   end

   // Outputs straight from the state register
   assign bus.scl          = q.scl;
   assign bus.sda_ctl_out  = 1'b0;
   assign bus.sda_ctl_oe_b = q.oe_b;
   assign cmd_ready        = q.ready;
   assign done             = q.done;
   assign rd_byte          = q.rd;
   assign ack_seen         = q.ack;
endmodule

`default_nettype wire

// [testbench/eeprom_assertions.sv]
// Bus checker for the EEPROM target and its controller.
// Assumes the interface signals and the target busy flag as plain inputs.
`default_nettype none

module eeprom_assertions #(
   parameter int WR_P = 3000 // Write cycle length in clocks
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Bus signals
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_tgt_out,
   input wire logic sda_tgt_oe_b,
   input wire logic sda_ctl_out,
   input wire logic sda_ctl_oe_b,
   // Target status
   input wire logic busy
);
   timeunit 1ns;
   timeprecision 100ps;
   // Longest target drive: acknowledge plus eight zero bits, four quarters each
   localparam int LOW_MAX = 36 * eeprom_pkg::SCL_QTR + 10;
   // Monitor state: counters and last bus levels
   typedef struct packed {
      logic [15:0] busy_cnt;
      logic [15:0] low_cnt;
      logic [7:0]  stop_age;
      logic        scl;
      logic        sda;
   } mon_t;
   mon_t q, d;

   // Busy length, drive length and age of the last stop
   always_comb begin
      d          = q;
      d.scl      = scl;
      d.sda      = sda;
      d.busy_cnt = busy ? q.busy_cnt + 16'h0001 : 16'h0000;
      d.low_cnt  = !sda_tgt_oe_b ? q.low_cnt + 16'h0001 : 16'h0000;
      // Saturates so an old stop never looks recent
      if (scl && q.scl && sda && !q.sda) begin
         d.stop_age = 8'h00;
      end else if (q.stop_age != 8'hFF) begin
         d.stop_age = q.stop_age + 8'h01;
      end
   end

   // Register the monitor state
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         // Idle bus levels and an old stop, so reset never looks like a stop
         q          <= '0;
         q.scl      <= 1'b1;
         q.sda      <= 1'b1;
         q.stop_age <= 8'hFF;
      end else begin
         q <= d;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   tgt_value_low_a: assert property (sda_tgt_out == 1'b0)
      else $error("target drive value is not low");
   tgt_edge_delay_a:
      assert property ($changed(sda_tgt_oe_b) |-> !$past(scl, 2) && ($past(scl, 4) || $past(scl, 5)))
      else $error("target data changed out of step with the clock fall");
   tgt_quiet_busy_a: assert property (busy |-> sda_tgt_oe_b)
      else $error("target drove the bus during its write cycle");
   busy_after_stop_a: assert property ($rose(busy) |-> scl && q.stop_age <= 8'h08)
      else $error("write cycle began without a stop");
   busy_hold_a: assert property ($rose(busy) |=> busy [*8])
      else $error("write cycle cut short");
   busy_length_a:
      assert property ($fell(busy) |-> q.busy_cnt >= WR_P - 1 && q.busy_cnt <= WR_P + 1)
      else $error("write cycle length wrong");
   tgt_drive_bound_a: assert property (q.low_cnt <= LOW_MAX)
      else $error("target held the data line too long");
   no_tgt_framing_a:
      assert property (scl && $past(scl) && $changed(sda) |-> sda_tgt_oe_b && $past(sda_tgt_oe_b))
      else $error("target changed data while the clock was high");

   // Main scenarios reached
   cover property ($fell(busy));
   cover property (!sda_tgt_oe_b && scl);
   cover property (scl && !sda_ctl_oe_b && !sda_ctl_out && $fell(sda));
endmodule

`default_nettype wire

// [testbench/testbench.sv]
// Self-checking bench: controller and EEPROM target on one shared bus.
// Assumes the package, the interface and both ends are compiled first.
`default_nettype none

module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import eeprom_pkg::*;
   localparam int WR_P = 3000;       // Shortened write cycle keeps the run brief
   localparam logic [2:0] STRAP = 3'h5; // Strap setting of the target
   localparam logic [7:0] DEV_W = {DEV_TYPE, STRAP, 1'b0};
   localparam logic [7:0] DEV_R = {DEV_TYPE, STRAP, 1'b1};
   logic       clk;           // System clock
   logic       rst_b;         // Reset, active low
   logic       cmd_valid;     // Command offered
   op_t        cmd_op;        // Command kind
   logic [7:0] cmd_byte;      // Byte to send
   logic       cmd_ack;       // Our acknowledge on reads
   logic       cmd_ready;     // Controller idle
   logic       done;          // Command finished
   logic [7:0] rd_byte;       // Byte read
   logic       ack_seen;      // Target acknowledged
   logic       write_protect; // Protect pin
   logic       busy;          // Target write cycle
   int         bad_count;     // Mismatches
   int         check_count;   // Comparisons
   int         cycles;        // Timeout counter

   two_wire_if bus_if ();
   eeprom_target #(.WR_CYCLES_P(WR_P)) eeprom_target_inst (
      .clk(clk), .rst_b(rst_b), .bus(bus_if), .chip_select_strap_2(STRAP[2]),
      .chip_select_strap_1(STRAP[1]), .chip_select_strap_0(STRAP[0]),
      .write_protect(write_protect), .busy(busy));
   bus_controller bus_controller_inst (
      .clk(clk), .rst_b(rst_b), .bus(bus_if), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
      .cmd_byte(cmd_byte), .cmd_ack(cmd_ack), .cmd_ready(cmd_ready), .done(done),
      .rd_byte(rd_byte), .ack_seen(ack_seen));
   eeprom_assertions #(.WR_P(WR_P)) eeprom_assertions_inst (
      .clk(clk), .rst_b(rst_b), .scl(bus_if.scl), .sda(bus_if.sda),
      .sda_tgt_out(bus_if.sda_tgt_out), .sda_tgt_oe_b(bus_if.sda_tgt_oe_b),
      .sda_ctl_out(bus_if.sda_ctl_out), .sda_ctl_oe_b(bus_if.sda_ctl_oe_b), .busy(busy));

   // 200 MHz clock
   always #2.5 clk = ~clk;

   // Verdict and end of run
   task automatic summarize();
      $display("checks %0d, mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Compare a flag
   task automatic check_bit(input string what, input logic exp, input logic got);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %b, seen %b", what, exp, got);
      end
   endtask

   // Compare a byte
   task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   // One controller command: offer until taken, then wait for done
   task automatic run(input op_t op, input logic [7:0] b, input logic a);
      int n;
      n = 0;
      cmd_op    <= op;
      cmd_byte  <= b;
      cmd_ack   <= a;
      cmd_valid <= 1'b1;
      do begin @(posedge clk); n++; end while (cmd_ready !== 1'b1 && n < 100);
      cmd_valid <= 1'b0;
      n = 0;
      do begin @(posedge clk); n++; end while (done !== 1'b1 && n < 20000);
      check_bit("done", 1'b1, done);
   endtask

   // Byte out, with the acknowledge expected back
   task automatic wr(input logic [7:0] b, input logic exp);
      run(OP_WRITE, b, 1'b0);
      check_bit("ack", exp, ack_seen);
   endtask

   // Byte in, answering with our acknowledge
   task automatic rd(input logic a, input logic [7:0] exp);
      run(OP_READ, 8'hFF, a);
      check_byte("read", exp, rd_byte);
   endtask

   // Wait out a write cycle, bounded
   task automatic wait_idle();
      int n;
      n = 0;
      while (busy === 1'b1 && n < 5000) begin @(posedge clk); n++; end
      check_bit("busy", 1'b0, busy);
   endtask

   // Hang guard: counts as a mismatch; the run needs about 45,000 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 65000) begin
         bad_count++;
         summarize();
      end
   end

   initial begin
      clk = 1'b0; rst_b = 1'b0; cmd_valid = 1'b0; cmd_op = OP_START; cmd_byte = 8'h00;
      cmd_ack = 1'b0; write_protect = 1'b0; bad_count = 0; check_count = 0; cycles = 0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      // Foreign straps get no acknowledge; recovery frees the bus
      run(OP_START, 8'h00, 1'b0);
      wr({DEV_TYPE, ~STRAP, 1'b0}, 1'b0);
      run(OP_RECOVER, 8'h00, 1'b0);
      // Byte write, top address bit ignored, then a poll while busy
      run(OP_START, 8'h00, 1'b0);
      wr(DEV_W, 1'b1);
      wr(8'hFF, 1'b1);
      wr(8'h5A, 1'b1);
      run(OP_STOP, 8'h00, 1'b0);
      check_bit("busy", 1'b1, busy);
      run(OP_START, 8'h00, 1'b0);
      wr(DEV_W, 1'b0);
      run(OP_STOP, 8'h00, 1'b0);
      wait_idle();
      // Page write from the end of page 0, wrapping to its start
      run(OP_START, 8'h00, 1'b0);
      wr(DEV_W, 1'b1);
      wr(8'h87, 1'b1);
      wr(8'hC3, 1'b1);
      wr(8'h96, 1'b1);
      wr(8'h69, 1'b1);
      run(OP_STOP, 8'h00, 1'b0);
      wait_idle();
      // Protected write: acknowledged, no write cycle
      write_protect <= 1'b1;
      run(OP_START, 8'h00, 1'b0);
      wr(DEV_W, 1'b1);
      wr(8'h01, 1'b1);
      wr(8'hEE, 1'b1);
      run(OP_STOP, 8'h00, 1'b0);
      check_bit("busy", 1'b0, busy);
      write_protect <= 1'b0;
      // Random read of the last byte
      run(OP_START, 8'h00, 1'b0);
      wr(DEV_W, 1'b1);
      wr(8'h7F, 1'b1);
      run(OP_START, 8'h00, 1'b0);
      wr(DEV_R, 1'b1);
      rd(1'b0, 8'h5A);
      run(OP_STOP, 8'h00, 1'b0);
      // Current read continues past the array end
      run(OP_START, 8'h00, 1'b0);
      wr(DEV_R, 1'b1);
      rd(1'b1, 8'h96);
      rd(1'b0, 8'h69);
      run(OP_STOP, 8'h00, 1'b0);
      summarize();
   end
endmodule

`default_nettype wire
